// File: rtl/sbs_pkg.sv
// package of constants and types for the synchronous burst sram access block
package sbs_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 17;
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;
   localparam int WORD_W      = LANES * LANE_W;
   localparam int DATA_W      = 32;
   localparam int BURST_LSB   = 0;
   localparam int BURST_W     = 2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS          = 4;
   localparam int SLEEP_ENTRY_CYC        = 2;
   localparam int SLEEP_RECOVERY_CYC     = 2;
   localparam int SLEEP_ENTRY_TIME_NS    = SLEEP_ENTRY_CYC * CLK_PERIOD_NS;
   localparam int SLEEP_RECOVERY_TIME_NS = SLEEP_RECOVERY_CYC * CLK_PERIOD_NS;
   // longest time rounds down, least time rounds up
   localparam int SLEEP_ENTRY_CNT    = (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
   localparam int SLEEP_RECOVERY_CNT = (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [1:0]  BURST_RST   = 2'h0;
   localparam logic [1:0]  BURST_STEP  = 2'h1;
   localparam logic [16:0] ADDR_RST    = 17'h00000;
   localparam logic [35:0] WORD_RST    = 36'h000000000;
   localparam logic        ORDER_LINEAR = 1'b0;

   typedef enum logic [3:0] {
      SBS_ACTIVE = 4'h1,
      SBS_ENTER  = 4'h2,
      SBS_SLEEP  = 4'h4,
      SBS_WAKE   = 4'h8
   } sbs_pwr_t;
endpackage

// File: rtl/sbs_mem.sv
// word memory with per-lane write and registered read data
module sbs_mem
   import sbs_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int NL = LANES,
   parameter int LW = LANE_W
)(
   input  wire logic             clk_sys,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [NL-1:0]    lane_we,
   input  wire logic [NL*LW-1:0] wdata,
   output logic      [NL*LW-1:0] rdata
);
   logic [NL*LW-1:0] mem [0:(1<<AW)-1];

   // ----------------------------------------------------------------
   // per-lane write, unselected lanes keep their contents
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NL; i++) begin
         if (lane_we[i]) begin
            mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
         end
      end
   end

   // read data leaves through a register; no reset so it maps to ram
   always_ff @(posedge clk_sys) begin
      rdata <= mem[addr];
   end
endmodule

// File: rtl/sbs_access.sv
// access control of a pipelined synchronous burst sram
module sbs_access
   import sbs_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int NL = LANES,
   parameter int LW = LANE_W
)(
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [AW-1:0]    addr_in,
   input  wire logic             controller_addr_strobe_n,
   input  wire logic             processor_addr_strobe_n,
   input  wire logic             burst_advance_n,
   input  wire logic             global_write_n,
   input  wire logic             byte_write_enable_n,
   input  wire logic [NL-1:0]    byte_lane_select_n,
   input  wire logic             chip_select_one_n,
   input  wire logic             chip_select_two,
   input  wire logic             chip_select_three_n,
   input  wire logic             sleep_request,
   input  wire logic             output_enable_n,
   input  wire logic             burst_order,
   input  wire logic [NL*LW-1:0] data_in,
   output logic      [NL*LW-1:0] data_out,
   output logic      [NL-1:0]    data_oe,
   output logic                  sleeping
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // next burst low address for the chosen order and step count
   function automatic logic [1:0] burst_next(input logic [1:0] start,
                                             input logic [1:0] cnt,
                                             input logic       order);
      if (order == ORDER_LINEAR) begin
         burst_next = start + cnt;
      end else begin
         burst_next = start ^ cnt;
      end
   endfunction

   // write condition from global, byte enable and lane selects
   function automatic logic write_cond(input logic gw_n, input logic bwe_n,
                                       input logic [NL-1:0] bw_n);
      write_cond = !gw_n || (!bwe_n && !(&bw_n));
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sbs_pwr_t         pwr_q;
   logic [1:0]       pwr_cnt_q;
   logic             zz_meta_q;
   logic             zz_sync_q;
   logic [AW-1:0]    addr_q;
   logic [1:0]       start_q;
   logic [1:0]       step_q;
   logic             burst_act_q;
   logic             burst_wr_q;
   logic             rd_pend_q;
   logic             rd_valid_q;
   logic             first_q;
   logic             order_q;
   logic [NL*LW-1:0] rdata;
   logic [AW-1:0]    mem_addr;
   logic [NL-1:0]    lane_we;
   logic [NL*LW-1:0] data_out_d;
   logic [NL-1:0]    data_oe_d;

   // ----------------------------------------------------------------
   // cycle decode
   // ----------------------------------------------------------------
   logic awake;
   logic sel_all;
   logic is_write;
   logic ctl_start;
   logic proc_start;
   logic start;
   logic deselect;
   logic continue_cyc;
   logic [1:0] step_d;

   // sleep request itself blanks all decode at once, the sync path only tracks state
   assign awake = (pwr_q == SBS_ACTIVE) && !sleep_request;
   assign sel_all = !chip_select_one_n && chip_select_two && !chip_select_three_n;
   assign is_write = write_cond(global_write_n, byte_write_enable_n, byte_lane_select_n);
   assign ctl_start = awake && !controller_addr_strobe_n && processor_addr_strobe_n
                      && sel_all;
   // processor strobe is ignored while chip select one is high
   assign proc_start = awake && !processor_addr_strobe_n && sel_all;
   assign start = ctl_start || proc_start;
   assign deselect = awake &&
                     ((chip_select_one_n && !controller_addr_strobe_n) ||
                      ((!chip_select_two || chip_select_three_n) &&
                       !(chip_select_one_n) &&
                       (!controller_addr_strobe_n ||
                        !processor_addr_strobe_n)));
   assign continue_cyc = awake && !start && !deselect && burst_act_q
                         && controller_addr_strobe_n
                         && (processor_addr_strobe_n || chip_select_one_n);
   // advance is only looked at in continue cycles, never in a start cycle
   assign step_d = (continue_cyc && !burst_advance_n) ? step_q + BURST_STEP
                                                        : step_q;

   // address to the array: external on start, counter otherwise
   always_comb begin
      mem_addr = addr_q;
      if (start) begin
         mem_addr = addr_in;
      end else begin
         mem_addr[BURST_LSB +: BURST_W] = burst_next(start_q, step_d, order_q);
      end
   end

   // lane strobes: global writes every lane, byte write only the selected ones
   always_comb begin
      lane_we = '0;
      if ((ctl_start || continue_cyc) && is_write) begin
         if (!global_write_n) begin
            lane_we = '1;
         end else begin
            lane_we = ~byte_lane_select_n;
         end
      end
   end

   sbs_mem #(
      .AW (AW),
      .NL (NL),
      .LW (LW)
   ) u_mem (
      .clk_sys (clk_sys),
      .addr    (mem_addr),
      .lane_we (lane_we),
      .wdata   (data_in),
      .rdata   (rdata)
   );

   // ----------------------------------------------------------------
   // sleep request synchroniser and power sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         zz_meta_q <= 1'b0;
         zz_sync_q <= 1'b0;
      end else begin
         zz_meta_q <= sleep_request;
         zz_sync_q <= zz_meta_q;
      end
   end

   // two cycles in, two cycles out; no access is taken until back to active
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pwr_q     <= SBS_ACTIVE;
         pwr_cnt_q <= 2'h0;
      end else begin
         case (pwr_q)
            SBS_ACTIVE: begin
               if (zz_sync_q) begin
                  pwr_q     <= SBS_ENTER;
                  pwr_cnt_q <= 2'(SLEEP_ENTRY_CNT - 1);
               end
            end
            SBS_ENTER: begin
               if (pwr_cnt_q == 2'h0) begin
                  pwr_q <= SBS_SLEEP;
               end else begin
                  pwr_cnt_q <= pwr_cnt_q - 2'h1;
               end
            end
            SBS_SLEEP: begin
               if (!zz_sync_q) begin
                  pwr_q     <= SBS_WAKE;
                  pwr_cnt_q <= 2'(SLEEP_RECOVERY_CNT - 1);
               end
            end
            SBS_WAKE: begin
               if (zz_sync_q) begin
                  pwr_q <= SBS_SLEEP;
               end else if (pwr_cnt_q == 2'h0) begin
                  pwr_q <= SBS_ACTIVE;
               end else begin
                  pwr_cnt_q <= pwr_cnt_q - 2'h1;
               end
            end
            default: begin
               pwr_q <= SBS_ACTIVE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // address register and burst counter
   // ----------------------------------------------------------------
   // strap is sampled once after reset; it must stay static anyway
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         first_q <= 1'b1;
         order_q <= 1'b1;
      end else if (first_q) begin
         first_q <= 1'b0;
         order_q <= burst_order;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         addr_q      <= ADDR_RST;
         start_q     <= BURST_RST;
         step_q      <= BURST_RST;
         burst_act_q <= 1'b0;
         burst_wr_q  <= 1'b0;
      end else if (!awake) begin
         burst_act_q <= 1'b0;
         burst_wr_q  <= 1'b0;
      end else if (start) begin
         addr_q      <= addr_in;
         start_q     <= addr_in[BURST_LSB +: BURST_W];
         step_q      <= BURST_RST;
         burst_act_q <= 1'b1;
         burst_wr_q  <= ctl_start && is_write;
      end else if (deselect) begin
         burst_act_q <= 1'b0;
         burst_wr_q  <= 1'b0;
      end else if (continue_cyc) begin
         step_q     <= step_d;
         burst_wr_q <= is_write;
      end
   end

   // ----------------------------------------------------------------
   // read pipeline and output drivers
   // ----------------------------------------------------------------
   // processor-strobe starts always read; a read is pending one edge later and valid two edges later
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rd_pend_q  <= 1'b0;
         rd_valid_q <= 1'b0;
      end else begin
         rd_pend_q  <= (proc_start || ((ctl_start || continue_cyc) && !is_write));
         rd_valid_q <= rd_pend_q && awake;
      end
   end

   // drive enable: only valid reads, never a write, deselect or sleep
   always_comb begin
      data_oe_d  = '0;
      data_out_d = rdata;
      // any write cycle masks the drivers, a controller write start included
      if (rd_pend_q && awake && !deselect && !(is_write && (ctl_start || continue_cyc))
          && !output_enable_n) begin
         data_oe_d = '1;
      end
   end

   // registered outputs; the enable level follows the output enable one edge behind
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         data_out <= WORD_RST;
         data_oe  <= '0;
         sleeping <= 1'b0;
      end else begin
         data_out <= data_out_d;
         data_oe  <= data_oe_d;
         sleeping <= (pwr_q == SBS_SLEEP);
      end
   end
endmodule

// File: sim/sbs_access_asserts.sv
// port checker for the sram access block, bound into sbs_access
module sbs_access_asserts
   import sbs_pkg::*;
#(
   parameter int NL = LANES
)(
   input wire logic          clk_sys,
   input wire logic          reset_n,
   input wire logic          controller_addr_strobe_n,
   input wire logic          processor_addr_strobe_n,
   input wire logic          global_write_n,
   input wire logic          byte_write_enable_n,
   input wire logic [NL-1:0] byte_lane_select_n,
   input wire logic          chip_select_one_n,
   input wire logic          chip_select_two,
   input wire logic          chip_select_three_n,
   input wire logic          sleep_request,
   input wire logic          output_enable_n,
   input wire logic [NL-1:0] data_oe,
   input wire logic          sleeping
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // cycle decode
   // ------------------------------------------------------------
   logic sel_w, wcond_w, wr_start_w, rd_start_w, cont_wr_w, dsel_w;
   // drive enables are registered, so checks look one edge after the cause
   assign sel_w = !chip_select_one_n && chip_select_two && !chip_select_three_n;
   assign wcond_w = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
   assign wr_start_w = !controller_addr_strobe_n && processor_addr_strobe_n && sel_w && wcond_w;
   assign rd_start_w = !processor_addr_strobe_n && sel_w;
   assign cont_wr_w = controller_addr_strobe_n && processor_addr_strobe_n && wcond_w;
   assign dsel_w = (chip_select_one_n && !controller_addr_strobe_n) ||
                   (!chip_select_one_n && (!chip_select_two || chip_select_three_n) &&
                    (!controller_addr_strobe_n || !processor_addr_strobe_n));
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------
   // sequences and checks
   // ------------------------------------------------------------
   sequence seq_quiet;
      (!sleep_request && !sleeping) [*8];
   endsequence
   sequence seq_read;
      seq_quiet ##0 rd_start_w ##1 (!output_enable_n && !wcond_w && !dsel_w && !sleep_request);
   endsequence
   sequence seq_wr_pair;
      wr_start_w ##1 wr_start_w;
   endsequence
   sequence seq_wr_cont;
      wr_start_w ##1 cont_wr_w;
   endsequence
   dsel_tristate_a: assert property (dsel_w [*2] |=> data_oe == '0)
      else $error("deselect left drivers on");
   write_tristate_a: assert property (seq_wr_pair |=> data_oe == '0)
      else $error("drivers on during writes");
   cont_write_off_a: assert property (seq_wr_cont |=> data_oe == '0)
      else $error("drivers on during burst write");
   oe_gate_a: assert property (output_enable_n |=> data_oe == '0)
      else $error("drivers on with output enable high");
   read_drive_a: assert property (seq_read |=> data_oe == '1)
      else $error("read data not driven");
   sleep_entry_a: assert property (sleep_request [*8] |=> sleeping)
      else $error("sleep not entered in time");
   sleep_exit_a: assert property ((!sleep_request) [*8] |=> !sleeping)
      else $error("sleep not left in time");
   sleep_quiet_a: assert property (sleeping && $past(sleeping) |-> data_oe == '0)
      else $error("drivers on while asleep");
endmodule
bind sbs_access sbs_access_asserts #(.NL(NL)) sbs_access_asserts_inst (
   .clk_sys, .reset_n, .controller_addr_strobe_n, .processor_addr_strobe_n,
   .global_write_n, .byte_write_enable_n, .byte_lane_select_n, .chip_select_one_n,
   .chip_select_two, .chip_select_three_n, .sleep_request, .output_enable_n,
   .data_oe, .sleeping
);

// File: sim/sbs_host.sv
// cache controller model driving strobes, selects and write data
module sbs_host
   import sbs_pkg::*;
(
   input  wire logic              clk_sys,
   output logic      [ADDR_W-1:0] addr_in,
   output logic                   controller_addr_strobe_n,
   output logic                   processor_addr_strobe_n,
   output logic                   burst_advance_n,
   output logic                   global_write_n,
   output logic                   byte_write_enable_n,
   output logic      [LANES-1:0]  byte_lane_select_n,
   output logic                   chip_select_one_n,
   output logic                   chip_select_two,
   output logic                   chip_select_three_n,
   output logic                   sleep_request,
   output logic                   output_enable_n,
   output logic      [WORD_W-1:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] SEL = 3'h2;
   // idle levels from time zero
   initial begin
      {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h6;
      {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n} = 3'h7;
      {global_write_n, byte_write_enable_n, output_enable_n, sleep_request} = 4'hE;
      byte_lane_select_n = 4'hF;
      addr_in = '0;
      data_in = '0;
   end
   // ------------------------------------------------------------
   // one bus cycle per call, launched after a falling edge
   // ------------------------------------------------------------
   task automatic drive(input logic [2:0] cs, input logic c, p, v, g, e,
                        input logic [3:0] b, input logic o, input logic [16:0] a,
                        input logic [35:0] d);
      logic w;
      w = !g || (!e && b != 4'hF);
      {chip_select_one_n, chip_select_two, chip_select_three_n} = cs;
      controller_addr_strobe_n = c;
      processor_addr_strobe_n = p;
      burst_advance_n = v;
      global_write_n = g;
      byte_write_enable_n = e;
      byte_lane_select_n = b;
      output_enable_n = o | w;
      addr_in = a;
      // released data shows the inverse so stale data never looks valid
      data_in = w ? d : ~data_in;
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [16:0] a, input logic g, input logic [3:0] b,
                     input logic [35:0] d, input logic v);
      drive(SEL, 1'h0, 1'h1, v, g, 1'h0, b, 1'h1, a, d);
   endtask
   task automatic cw(input logic v, input logic [35:0] d);
      drive(SEL, 1'h1, 1'h1, v, 1'h0, 1'h1, 4'hF, 1'h1, addr_in, d);
   endtask
   task automatic rd(input logic [16:0] a);
      drive(SEL, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, 1'h0, a, '0);
   endtask
   task automatic nx(input logic v);
      drive(SEL, 1'h1, 1'h1, v, 1'h1, 1'h1, 4'hF, 1'h0, addr_in, '0);
   endtask
   // idle keeps the writes off but shakes advance, lane selects and output enable
   task automatic idle(input int n);
      repeat (n) drive(3'h6, 1'h1, 1'h1, 1'($urandom), 1'h1, 1'h1, 4'($urandom),
                       1'($urandom), addr_in, '0);
   endtask
   // sleep only while deselected; selects stay idle after release
   task automatic zz(input logic on);
      idle(1);
      sleep_request = on;
      @(negedge clk_sys);
      if (!on)
         idle(SLEEP_RECOVERY_CYC + 8);
   endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the sram access block
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   $display("mismatch %s expected %h seen %h", n, e, s); bad_count++; end end
module tb_top;
   import sbs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys, reset_n, burst_order, sleeping;
   logic              controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n;
   logic              global_write_n, byte_write_enable_n, chip_select_one_n;
   logic              chip_select_two, chip_select_three_n, sleep_request, output_enable_n;
   logic [ADDR_W-1:0] addr_in, a;
   logic [LANES-1:0]  byte_lane_select_n, data_oe;
   logic [WORD_W-1:0] data_in, data_out, d;
   logic [WORD_W-1:0] mem [int];
   logic [2:0]        dsel_cs [3] = '{3'h6, 3'h0, 3'h3};
   int                bad_count, check_count;
   sbs_access sbs_access_inst (
      .clk_sys, .reset_n, .addr_in, .controller_addr_strobe_n, .processor_addr_strobe_n,
      .burst_advance_n, .global_write_n, .byte_write_enable_n, .byte_lane_select_n,
      .chip_select_one_n, .chip_select_two, .chip_select_three_n, .sleep_request,
      .output_enable_n, .burst_order, .data_in, .data_out, .data_oe, .sleeping
   );
   sbs_host sbs_host_inst (
      .clk_sys, .addr_in, .controller_addr_strobe_n, .processor_addr_strobe_n,
      .burst_advance_n, .global_write_n, .byte_write_enable_n, .byte_lane_select_n,
      .chip_select_one_n, .chip_select_two, .chip_select_three_n, .sleep_request,
      .output_enable_n, .data_in
   );
   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // reference model and helpers
   // ------------------------------------------------------------
   function automatic logic [WORD_W-1:0] rnd();
      rnd = {4'($urandom), $urandom};
   endfunction
   // k-th burst address from the start word in the strapped order
   function automatic logic [16:0] seqa(input logic [16:0] b, input int k);
      seqa = b;
      seqa[1:0] = burst_order ? b[1:0] ^ k[1:0] : b[1:0] + k[1:0];
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // the strap only moves while reset is held
   task automatic do_reset(input logic o);
      reset_n = 1'h0;
      burst_order = o;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'h1;
      sbs_host_inst.idle(2);
   endtask
   task automatic rcheck(input logic [16:0] ra);
      sbs_host_inst.rd(ra);
      sbs_host_inst.nx(1'h1);
      sbs_host_inst.nx(1'h1);
      `CHK("read word", mem[ra], data_out);
      `CHK("lane drive", 4'hF, data_oe);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'h0;
      burst_order = 1'h1;
      bad_count = 0;
      check_count = 0;
      void'($urandom(32'h830a3e46));
      @(negedge clk_sys);
      // bursts in both orders; a held advance repeats the last word
      for (int o = 1; o >= 0; o--) begin
         do_reset(o[0]);
         a = 17'($urandom);
         d = rnd();
         sbs_host_inst.wr(a, 1'h0, 4'hF, d, 1'h0);
         mem[seqa(a, 0)] = d;
         for (int k = 1; k < 5; k++) begin
            d = rnd();
            sbs_host_inst.cw(k == 4, d);
            mem[seqa(a, k > 3 ? 3 : k)] = d;
         end
         // read data stands two edges after its address, advance steps three times
         sbs_host_inst.rd(a);
         for (int k = 0; k < 4; k++) begin
            sbs_host_inst.nx(k >= 3);
            `CHK("burst word", mem[seqa(a, k)], data_out);
         end
      end
      // every lane select pattern, back to back with a global write
      a = 17'($urandom);
      d = rnd();
      sbs_host_inst.wr(a, 1'h0, 4'($urandom), d, 1'h1);
      mem[a] = d;
      for (int m = 0; m < 16; m++) begin
         d = rnd();
         sbs_host_inst.wr(a, 1'h1, m[3:0], d, 1'h1);
         for (int i = 0; i < 4; i++)
            if (!m[i])
               mem[a][i*9 +: 9] = d[i*9 +: 9];
         rcheck(a);
      end
      // deselected write strobes must not store
      foreach (dsel_cs[i]) begin
         repeat (2) sbs_host_inst.drive(dsel_cs[i], 1'h0, 1'h1, 1'h1, 1'h0, 1'h1,
                                        4'hF, 1'h1, a, rnd());
         rcheck(a);
      end
      // a write while asleep is ignored and contents survive
      sbs_host_inst.zz(1'h1);
      sbs_host_inst.idle(4);
      sbs_host_inst.wr(a, 1'h0, 4'hF, rnd(), 1'h1);
      sbs_host_inst.idle(8);
      `CHK("asleep", 1'h1, sleeping);
      sbs_host_inst.zz(1'h0);
      `CHK("awake", 1'h0, sleeping);
      rcheck(a);
      finish_test;
   end
   // hang guard, far beyond the roughly 140 cycles of the run
   initial begin
      repeat (4000) @(posedge clk_sys);
      bad_count++;
      finish_test;
   end
endmodule
